// file: dgt_timer_top.sv
// dual general timer block with baud-rate timer and banked io port access
`timescale 1ns/1ps
`include "dgt_defines.svh"
module dgt_timer_top (
    // clock and reset
    input  wire logic              clock_i,
    input  wire logic              nrst_i,

    // banked io port from the cpu core
    input  wire dgt_pkg::dgt_addr_t io_bank_i,
    input  wire dgt_pkg::dgt_addr_t io_port_i,
    input  wire logic              io_wr_i,
    input  wire logic              io_rd_i,
    input  wire dgt_pkg::dgt_word_t io_wdata_i,
    output dgt_pkg::dgt_word_t     io_rdata_o,

    // external count pins
    input  wire logic              first_external_count_pin_i,
    input  wire logic              second_external_count_pin_i,

    // interrupt mask from the interrupt controller
    input  wire dgt_pkg::dgt_word_t interrupt_mask_register_i,

    // interrupt requests
    output logic                   first_period_interrupt_o,
    output logic                   second_period_interrupt_o,
    output logic                   baud_counter_interrupt_o,

    // compare subsystem settings
    output logic [4:0]             compare_settings_o
);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    dgt_pkg::dgt_word_t timer_control;
    dgt_pkg::dgt_word_t timer_one_period;
    dgt_pkg::dgt_word_t timer_two_period;
    dgt_pkg::dgt_word_t baud_rate_period;
    dgt_pkg::dgt_word_t next_timer_control;
    dgt_pkg::dgt_word_t next_timer_one_period;
    dgt_pkg::dgt_word_t next_timer_two_period;
    dgt_pkg::dgt_word_t next_baud_rate_period;

    // read data register
    dgt_pkg::dgt_word_t next_io_rdata;

    // counter values and wrap pulses
    dgt_pkg::dgt_word_t first_general_counter;
    dgt_pkg::dgt_word_t second_general_counter;
    dgt_pkg::dgt_word_t baud_rate_counter;
    logic               first_wrap;
    logic               second_wrap;
    logic               baud_wrap;

    // address decode strobes
    logic               sel_timers;
    logic               wr_count_one;
    logic               wr_period_one;
    logic               wr_count_two;
    logic               wr_period_two;
    logic               wr_control;
    logic               wr_baud_period;
    logic               wr_baud_count;

    // pin synchronisers and edge detect
    logic               pin_one_meta;
    logic               pin_one_sync;
    logic               pin_one_last;
    logic               pin_two_meta;
    logic               pin_two_sync;
    logic               pin_two_last;
    logic               pin_one_rise;
    logic               pin_two_rise;

    // raw and prescaled count ticks
    logic               raw_tick_one;
    logic               raw_tick_two;
    logic               tick_one;
    logic               tick_two;

    // control fields
    logic               src_one;
    dgt_pkg::dgt_code_t pre_one;
    dgt_pkg::dgt_code_t src_two;
    dgt_pkg::dgt_code_t pre_two;

    // ------------------------------------------------------------
    // control field extraction
    // ------------------------------------------------------------
    assign src_one = timer_control[`DGT_F_SRC_ONE];
    assign pre_one = timer_control[`DGT_F_PRE_ONE_HI:`DGT_F_PRE_ONE_LO];
    assign src_two = timer_control[`DGT_F_SRC_TWO_HI:`DGT_F_SRC_TWO_LO];
    assign pre_two = timer_control[`DGT_F_PRE_TWO_HI:`DGT_F_PRE_TWO_LO];

    // compare bits are held here for the compare block
    assign compare_settings_o = timer_control[`DGT_F_CMP_HI:`DGT_F_CMP_LO];

    // ------------------------------------------------------------
    // io port address decode
    // ------------------------------------------------------------
    assign sel_timers     = io_wr_i && (io_bank_i == `DGT_BANK_TIMERS);
    assign wr_count_one   = sel_timers && (io_port_i == `DGT_PORT_COUNT_ONE);
    assign wr_period_one  = sel_timers && (io_port_i == `DGT_PORT_PERIOD_ONE);
    assign wr_count_two   = sel_timers && (io_port_i == `DGT_PORT_COUNT_TWO);
    assign wr_period_two  = sel_timers && (io_port_i == `DGT_PORT_PERIOD_TWO);
    assign wr_control     = sel_timers && (io_port_i == `DGT_PORT_CONTROL);
    assign wr_baud_period = io_wr_i && (io_bank_i == `DGT_BANK_BAUD_PERIOD)
                            && (io_port_i == `DGT_PORT_BAUD);
    assign wr_baud_count  = io_wr_i && (io_bank_i == `DGT_BANK_BAUD_COUNT)
                            && (io_port_i == `DGT_PORT_BAUD);

    // ------------------------------------------------------------
    // writable registers: next values
    // ------------------------------------------------------------
    always_comb begin
        next_timer_control    = timer_control;
        next_timer_one_period = timer_one_period;
        next_timer_two_period = timer_two_period;
        next_baud_rate_period = baud_rate_period;
        if (wr_control) begin
            next_timer_control = io_wdata_i;    // bit 3 kept as written, software writes 0
        end
        if (wr_period_one) begin
            next_timer_one_period = io_wdata_i;
        end
        if (wr_period_two) begin
            next_timer_two_period = io_wdata_i;
        end
        if (wr_baud_period) begin
            next_baud_rate_period = io_wdata_i;
        end
    end

    // writable registers: storage
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            timer_control    <= `DGT_RST_CONTROL;
            timer_one_period <= `DGT_RST_PERIOD;
            timer_two_period <= `DGT_RST_PERIOD;
            baud_rate_period <= `DGT_RST_BAUD_PERIOD;
        end else begin
            timer_control    <= next_timer_control;
            timer_one_period <= next_timer_one_period;
            timer_two_period <= next_timer_two_period;
            baud_rate_period <= next_baud_rate_period;
        end
    end

    // ------------------------------------------------------------
    // read path, one cycle after the read strobe
    // ------------------------------------------------------------
    always_comb begin
        next_io_rdata = 16'h0000;
        if (io_rd_i) begin
            if (io_bank_i == `DGT_BANK_TIMERS) begin
                case (io_port_i)
                    `DGT_PORT_COUNT_ONE:  next_io_rdata = first_general_counter;
                    `DGT_PORT_PERIOD_ONE: next_io_rdata = timer_one_period;
                    `DGT_PORT_COUNT_TWO:  next_io_rdata = second_general_counter;
                    `DGT_PORT_PERIOD_TWO: next_io_rdata = timer_two_period;
                    `DGT_PORT_CONTROL:    next_io_rdata = timer_control;
                    default:              next_io_rdata = 16'h0000;
                endcase
            end else if (io_port_i == `DGT_PORT_BAUD) begin
                if (io_bank_i == `DGT_BANK_BAUD_PERIOD) begin
                    next_io_rdata = baud_rate_period;
                end else if (io_bank_i == `DGT_BANK_BAUD_COUNT) begin
                    next_io_rdata = baud_rate_counter;
                end
            end
        end
    end

    // read data register
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            io_rdata_o <= 16'h0000;
        end else begin
            io_rdata_o <= next_io_rdata;
        end
    end

    // ------------------------------------------------------------
    // external pin synchronisers; edge taken after the second stage
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_one_meta <= 1'b0;
            pin_one_sync <= 1'b0;
            pin_one_last <= 1'b0;
            pin_two_meta <= 1'b0;
            pin_two_sync <= 1'b0;
            pin_two_last <= 1'b0;
        end else begin
            pin_one_meta <= first_external_count_pin_i;
            pin_one_sync <= pin_one_meta;
            pin_one_last <= pin_one_sync;
            pin_two_meta <= second_external_count_pin_i;
            pin_two_sync <= pin_two_meta;
            pin_two_last <= pin_two_sync;
        end
    end

    // rising edges; pins slower than half the clock are never missed
    assign pin_one_rise = pin_one_sync && !pin_one_last;
    assign pin_two_rise = pin_two_sync && !pin_two_last;

    // ------------------------------------------------------------
    // count source selection
    // ------------------------------------------------------------
    always_comb begin
        raw_tick_one = src_one ? pin_one_rise : 1'b1;
        case (src_two)
            `DGT_SRC2_CLOCK:   raw_tick_two = 1'b1;
            `DGT_SRC2_CASCADE: raw_tick_two = first_wrap;
            `DGT_SRC2_PIN:     raw_tick_two = pin_two_rise;
            default:           raw_tick_two = 1'b0;    // unlisted code gives no ticks
        endcase
    end

    // ------------------------------------------------------------
    // prescalers
    // ------------------------------------------------------------
    dgt_prescaler u_pre_one (
        .clock_i (clock_i),
        .nrst_i  (nrst_i),
        .tick_i  (raw_tick_one),
        .sel_i   (pre_one),
        .tick_o  (tick_one)
    );

    dgt_prescaler u_pre_two (
        .clock_i (clock_i),
        .nrst_i  (nrst_i),
        .tick_i  (raw_tick_two),
        .sel_i   (pre_two),
        .tick_o  (tick_two)
    );

    // ------------------------------------------------------------
    // counters
    // ------------------------------------------------------------
    dgt_counter16 u_cnt_one (
        .clock_i  (clock_i),
        .nrst_i   (nrst_i),
        .tick_i   (tick_one),
        .period_i (timer_one_period),
        .wr_i     (wr_count_one),
        .wdata_i  (io_wdata_i),
        .count_o  (first_general_counter),
        .wrap_o   (first_wrap)
    );

    dgt_counter16 u_cnt_two (
        .clock_i  (clock_i),
        .nrst_i   (nrst_i),
        .tick_i   (tick_two),
        .period_i (timer_two_period),
        .wr_i     (wr_count_two),
        .wdata_i  (io_wdata_i),
        .count_o  (second_general_counter),
        .wrap_o   (second_wrap)
    );

    // baud-rate counter always runs on the instruction clock
    dgt_counter16 u_cnt_baud (
        .clock_i  (clock_i),
        .nrst_i   (nrst_i),
        .tick_i   (1'b1),
        .period_i (baud_rate_period),
        .wr_i     (wr_baud_count),
        .wdata_i  (io_wdata_i),
        .count_o  (baud_rate_counter),
        .wrap_o   (baud_wrap)
    );

    // ------------------------------------------------------------
    // masked interrupt pulses
    // ------------------------------------------------------------
    assign first_period_interrupt_o  = first_wrap
                                       && !interrupt_mask_register_i[`DGT_MASK_ONE];
    assign second_period_interrupt_o = second_wrap
                                       && !interrupt_mask_register_i[`DGT_MASK_TWO];
    assign baud_counter_interrupt_o  = baud_wrap
                                       && !interrupt_mask_register_i[`DGT_MASK_BAUD];

endmodule // dgt_timer_top

// file: dgt_defines.svh
// constants of the dual general timer block: bus map, fields, reset values
//
// Function
// - each general timer counts up 16 bits, clears after period match and interrupts on the same edge
// - control bit 0 picks first timer source: instruction clock or first pin
// - external source counts rising pin edges; pin rate at most half clock
// - control bits 2:1 prescale first timer: stop, by 4, by 16, by 1
// - control bits 7:6 prescale second timer: stop, by 4, by 16, by 1
// - control bits 5:4 pick second source: clock, first timer, second pin
// - cascaded, second timer counts first timer wraps, forming one 32-bit counter
// - reset clears the whole control register, so both timers stop
// - counters read/write; first match clears, flags bit 4, mask bit 4 blocks
// - second match clears counter, flags bit 5, mask bit 5 blocks it
// - reset loads both period registers with FFFFh
// - bank 2 ports 0..4: count1, period1, count2, period2, control
// - baud counter is a clock-only 16-bit timer, own period, flag bit 12
// - control bits 8 to 12 hold compare settings for the compare block
`ifndef DGT_DEFINES_SVH
`define DGT_DEFINES_SVH

// io banks and ports
`define DGT_BANK_TIMERS      3'h2
`define DGT_PORT_COUNT_ONE   3'h0
`define DGT_PORT_PERIOD_ONE  3'h1
`define DGT_PORT_COUNT_TWO   3'h2
`define DGT_PORT_PERIOD_TWO  3'h3
`define DGT_PORT_CONTROL     3'h4
`define DGT_BANK_BAUD_PERIOD 3'h5
`define DGT_BANK_BAUD_COUNT  3'h7
`define DGT_PORT_BAUD        3'h5

// control register fields
`define DGT_F_SRC_ONE        0
`define DGT_F_PRE_ONE_LO     1
`define DGT_F_PRE_ONE_HI     2
`define DGT_F_SRC_TWO_LO     4
`define DGT_F_SRC_TWO_HI     5
`define DGT_F_PRE_TWO_LO     6
`define DGT_F_PRE_TWO_HI     7
`define DGT_F_CMP_LO         8
`define DGT_F_CMP_HI         12

// field codes
`define DGT_PRE_STOP         2'h0
`define DGT_PRE_DIV4         2'h1
`define DGT_PRE_DIV16        2'h2
`define DGT_PRE_DIV1         2'h3
`define DGT_SRC2_CLOCK       2'h0
`define DGT_SRC2_CASCADE     2'h2
`define DGT_SRC2_PIN         2'h3
`define DGT_DIV4_LAST        4'h3
`define DGT_DIV16_LAST       4'hF

// interrupt mask bit positions
`define DGT_MASK_ONE         4
`define DGT_MASK_TWO         5
`define DGT_MASK_BAUD        12

// reset values
`define DGT_RST_CONTROL      16'h0000
`define DGT_RST_PERIOD       16'hFFFF
`define DGT_RST_COUNT        16'h0000
`define DGT_RST_BAUD_PERIOD  16'hFFFF

`endif

// file: dgt_pkg.sv
// types shared by the dual general timer block
package dgt_pkg;
    typedef logic [15:0] dgt_word_t;
    typedef logic [2:0]  dgt_addr_t;
    typedef logic [1:0]  dgt_code_t;
endpackage

// file: dgt_prescaler.sv
// tick prescaler: stop, divide by 4, by 16 or pass through
`timescale 1ns/1ps
`include "dgt_defines.svh"
module dgt_prescaler (
    // clock and reset
    input  wire logic             clock_i,
    input  wire logic             nrst_i,
    // ticks
    input  wire logic             tick_i,
    input  wire dgt_pkg::dgt_code_t sel_i,
    output logic                  tick_o
);
    logic [3:0] div_cnt;
    logic [3:0] next_div_cnt;

    // divider count and output tick
    always_comb begin
        next_div_cnt = div_cnt;
        tick_o       = 1'b0;
        case (sel_i)
            `DGT_PRE_STOP: begin
                next_div_cnt = 4'h0;
            end
            `DGT_PRE_DIV4: begin
                if (tick_i) begin
                    tick_o       = ({2'h0, div_cnt[1:0]} == `DGT_DIV4_LAST);
                    next_div_cnt = {2'h0, div_cnt[1:0] + 2'h1};
                end
            end
            `DGT_PRE_DIV16: begin
                if (tick_i) begin
                    tick_o       = (div_cnt == `DGT_DIV16_LAST);
                    next_div_cnt = div_cnt + 4'h1;
                end
            end
            default: begin
                tick_o       = tick_i;
                next_div_cnt = 4'h0;
            end
        endcase
    end

    // divider register
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_cnt <= 4'h0;
        end else begin
            div_cnt <= next_div_cnt;
        end
    end
endmodule // dgt_prescaler

// file: dgt_counter16.sv
// 16-bit up counter with period match, write port and wrap pulse
`timescale 1ns/1ps
`include "dgt_defines.svh"
module dgt_counter16 (
    // clock and reset
    input  wire logic              clock_i,
    input  wire logic              nrst_i,
    // count control
    input  wire logic              tick_i,
    input  wire dgt_pkg::dgt_word_t period_i,
    // cpu write
    input  wire logic              wr_i,
    input  wire dgt_pkg::dgt_word_t wdata_i,
    // state
    output dgt_pkg::dgt_word_t     count_o,
    output logic                   wrap_o
);
    dgt_pkg::dgt_word_t next_count;
    logic               next_wrap;

    // count, clear after match, cpu write wins
    always_comb begin
        next_count = count_o;
        next_wrap  = 1'b0;
        if (wr_i) begin
            next_count = wdata_i;
        end else if (tick_i) begin
            if (count_o == period_i) begin
                next_count = `DGT_RST_COUNT;
                next_wrap  = 1'b1;
            end else begin
                next_count = count_o + 16'h0001;
            end
        end
    end

    // count and wrap registers
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            count_o <= `DGT_RST_COUNT;
            wrap_o  <= 1'b0;
        end else begin
            count_o <= next_count;
            wrap_o  <= next_wrap;
        end
    end
endmodule // dgt_counter16

// file: dgt_timer_chk.sv
// port assertions for the dual general timer block
`timescale 1ns/1ps
`include "dgt_defines.svh"
module dgt_timer_chk (
    // clock and reset
    input  wire logic               clock_i,
    input  wire logic               nrst_i,
    // banked io port
    input  wire dgt_pkg::dgt_addr_t io_bank_i,
    input  wire dgt_pkg::dgt_addr_t io_port_i,
    input  wire logic               io_wr_i,
    input  wire logic               io_rd_i,
    input  wire dgt_pkg::dgt_word_t io_wdata_i,
    input  wire dgt_pkg::dgt_word_t io_rdata_o,
    // pins and mask
    input  wire logic               first_external_count_pin_i,
    input  wire logic               second_external_count_pin_i,
    input  wire dgt_pkg::dgt_word_t interrupt_mask_register_i,
    // interrupts and compare field
    input  wire logic               first_period_interrupt_o,
    input  wire logic               second_period_interrupt_o,
    input  wire logic               baud_counter_interrupt_o,
    input  wire logic [4:0]         compare_settings_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    logic       ctl_hit;
    logic       mapped;
    logic [4:0] wr_cmp;
    logic       ctl_seen;
    logic       next_ctl_seen;
    // address decode seen from the bus
    assign ctl_hit = (io_bank_i == 3'h2) && (io_port_i == 3'h4);
    assign mapped  = (io_bank_i == 3'h2 && io_port_i <= 3'h4)
                   || (io_port_i == 3'h5 && (io_bank_i == 3'h5 || io_bank_i == 3'h7));
    assign wr_cmp  = io_wdata_i[12:8];
    // remembers any control write since reset
    always_comb next_ctl_seen = ctl_seen | (io_wr_i & ctl_hit);
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) ctl_seen <= 1'b0;
        else ctl_seen <= next_ctl_seen;
    end
    rdata_idle_a: assert property (!io_rd_i |=> io_rdata_o == 16'h0000)
        else $error("read data not zero after idle cycle");
    rd_unmapped_a: assert property (io_rd_i && !mapped |=> io_rdata_o == 16'h0000)
        else $error("unmapped read returned data");
    ctl_readback_a: assert property (io_wr_i && ctl_hit ##1 !io_wr_i
        ##1 (io_rd_i && ctl_hit && !io_wr_i) |=> io_rdata_o == $past(io_wdata_i, 3))
        else $error("control read back differs from write");
    ctl_reset_a: assert property (!ctl_seen |-> compare_settings_o == 5'h00)
        else $error("compare field not clear after reset");
    cmp_follow_a: assert property (io_wr_i && ctl_hit |=> compare_settings_o == $past(wr_cmp))
        else $error("compare field does not follow control write");
    mask_one_a: assert property (interrupt_mask_register_i[4] |-> !first_period_interrupt_o)
        else $error("first interrupt passed its mask");
    mask_two_a: assert property (interrupt_mask_register_i[5] |-> !second_period_interrupt_o)
        else $error("second interrupt passed its mask");
    mask_baud_a: assert property (interrupt_mask_register_i[12] |-> !baud_counter_interrupt_o)
        else $error("baud interrupt passed its mask");
    pulse_one_a: assert property (first_period_interrupt_o |=> !first_period_interrupt_o)
        else $error("first interrupt longer than one cycle");
    pulse_two_a: assert property (second_period_interrupt_o |=> !second_period_interrupt_o)
        else $error("second interrupt longer than one cycle");
    // main scenarios reached
    cover property (first_period_interrupt_o);
    cover property (second_period_interrupt_o);
    cover property (baud_counter_interrupt_o);
endmodule // dgt_timer_chk

bind dgt_timer_top dgt_timer_chk u_chk (
    .clock_i(clock_i), .nrst_i(nrst_i), .io_bank_i(io_bank_i), .io_port_i(io_port_i),
    .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
    .first_external_count_pin_i(first_external_count_pin_i),
    .second_external_count_pin_i(second_external_count_pin_i),
    .interrupt_mask_register_i(interrupt_mask_register_i),
    .first_period_interrupt_o(first_period_interrupt_o),
    .second_period_interrupt_o(second_period_interrupt_o),
    .baud_counter_interrupt_o(baud_counter_interrupt_o),
    .compare_settings_o(compare_settings_o));

// file: dgt_cpu_model.sv
// cpu core model driving the banked io port
`timescale 1ns/1ps
module dgt_cpu_model (
    // clock
    input  wire logic               clock_i,
    // banked io port
    output dgt_pkg::dgt_addr_t      io_bank_o,
    output dgt_pkg::dgt_addr_t      io_port_o,
    output logic                    io_wr_o,
    output logic                    io_rd_o,
    output dgt_pkg::dgt_word_t      io_wdata_o,
    input  wire dgt_pkg::dgt_word_t io_rdata_i
);
    // idle bus at time zero
    initial begin
        io_bank_o = 3'h0;
        io_port_o = 3'h0;
        io_wr_o = 1'b0;
        io_rd_o = 1'b0;
        io_wdata_o = 16'h0000;
    end
    // one access held to its taking edge, released just after it
    task automatic access(input logic wr, input dgt_pkg::dgt_addr_t bank, port,
                          input dgt_pkg::dgt_word_t data, output dgt_pkg::dgt_word_t rdata);
        @(posedge clock_i);
        #5;
        io_bank_o = bank;
        io_port_o = port;
        io_wr_o = wr;
        io_rd_o = !wr;
        io_wdata_o = (bank == 3'h2 && port == 3'h4) ? (data & 16'hFFF7) : data;
        @(posedge clock_i);
        #5;
        rdata = io_rdata_i;
        io_wr_o = 1'b0;
        io_rd_o = 1'b0;
        io_bank_o = ~io_bank_o;
        io_port_o = ~io_port_o;
        io_wdata_o = ~io_wdata_o;
    endtask
endmodule // dgt_cpu_model

// file: testbench.sv
// self-checking testbench of the dual general timer block
`timescale 1ns/1ps
`include "dgt_defines.svh"
module testbench;
    logic               clock_i;
    logic               nrst_i = 1'b0;
    dgt_pkg::dgt_addr_t io_bank, io_port;
    logic               io_wr, io_rd, pin_one = 1'b0, pin_two = 1'b0, pin_run = 1'b0;
    dgt_pkg::dgt_word_t io_wdata, io_rdata, mask = 16'h0000, v, w;
    logic [2:0]         irq;
    logic [2:0]         ph = 3'h0;
    logic [4:0]         cmp_set;
    dgt_pkg::dgt_code_t codes [3];
    int                 fails = 0, num_checks = 0, cyc = 0, p, q, gap;
    // design and cpu model
    dgt_timer_top u_dut (.clock_i(clock_i), .nrst_i(nrst_i), .io_bank_i(io_bank),
        .io_port_i(io_port), .io_wr_i(io_wr), .io_rd_i(io_rd), .io_wdata_i(io_wdata),
        .io_rdata_o(io_rdata), .first_external_count_pin_i(pin_one),
        .second_external_count_pin_i(pin_two), .interrupt_mask_register_i(mask),
        .first_period_interrupt_o(irq[0]), .second_period_interrupt_o(irq[1]),
        .baud_counter_interrupt_o(irq[2]), .compare_settings_o(cmp_set));
    dgt_cpu_model u_cpu (.clock_i(clock_i), .io_bank_o(io_bank), .io_port_o(io_port),
        .io_wr_o(io_wr), .io_rd_o(io_rd), .io_wdata_o(io_wdata), .io_rdata_i(io_rdata));
    // clock
    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    // pins rise every 8 clocks, below half the clock rate
    always @(posedge clock_i) begin
        #5;
        ph = ph + 3'h1;
        pin_one = pin_run & ~ph[2];
        pin_two = pin_run & (ph[2] ^ ph[1]);
    end
    // hang guard
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            complete_run();
        end
    end
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk_word(input dgt_pkg::dgt_word_t got, exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_count(input int got, exp);
        num_checks++;
        if (got != exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input dgt_pkg::dgt_addr_t b, o, input dgt_pkg::dgt_word_t d);
        u_cpu.access(1'b1, b, o, d, w);
    endtask
    task automatic rd(input dgt_pkg::dgt_addr_t b, o, output dgt_pkg::dgt_word_t d);
        u_cpu.access(1'b0, b, o, 16'h0000, d);
    endtask
    // cycles between two interrupt pulses, 0 when none comes
    task automatic measure(input int sel, output int g);
        int n;
        n = 0;
        g = 0;
        do begin @(posedge clock_i); #5; n++; end while (!irq[sel] && n < 400);
        if (irq[sel] === 1'b1) begin
            do begin @(posedge clock_i); #5; g++; end while (!irq[sel] && g < 400);
        end
    endtask
    function automatic int div_of(input dgt_pkg::dgt_code_t c);
        return (c == `DGT_PRE_DIV4) ? 4 : ((c == `DGT_PRE_DIV16) ? 16 : 1);
    endfunction
    function automatic dgt_pkg::dgt_word_t ctl(input logic s1, input dgt_pkg::dgt_code_t p1, s2, p2);
        return {8'h00, p2, s2, 1'b0, p1, s1};
    endfunction
    // restart both counters with given periods and control
    task automatic start(input int a, b, input dgt_pkg::dgt_word_t c);
        wr(3'h2, 3'h4, 16'h0000);
        wr(3'h2, 3'h1, 16'(a));
        wr(3'h2, 3'h3, 16'(b));
        wr(3'h2, 3'h0, 16'h0000);
        wr(3'h2, 3'h2, 16'h0000);
        wr(3'h2, 3'h4, c);
    endtask
    // main sequence
    initial begin
        void'($urandom(32'hCF9D1C45));
        repeat (16) @(posedge clock_i);
        #5;
        nrst_i = 1'b1;
        rd(3'h2, 3'h4, v); chk_word(v, 16'h0000);
        rd(3'h2, 3'h1, v); chk_word(v, 16'hFFFF);
        rd(3'h2, 3'h3, v); chk_word(v, 16'hFFFF);
        rd(3'h5, 3'h5, v); chk_word(v, `DGT_RST_BAUD_PERIOD);
        rd(3'h2, 3'h6, v); chk_word(v, 16'h0000);
        rd(3'h3, 3'h0, v); chk_word(v, 16'h0000);
        q = $urandom;
        wr(3'h2, 3'h0, 16'(q)); rd(3'h2, 3'h0, v); chk_word(v, 16'(q));
        wr(3'h2, 3'h2, ~16'(q)); rd(3'h2, 3'h2, v); chk_word(v, ~16'(q));
        q = $urandom;
        wr(3'h2, 3'h4, 16'(q)); rd(3'h2, 3'h4, v); chk_word(v, 16'(q) & 16'hFFF7);
        chk_word({11'h000, cmp_set}, {11'h000, 5'(q >> 8)});
        $display("test registers done");
        codes = '{`DGT_PRE_DIV1, `DGT_PRE_DIV4, `DGT_PRE_DIV16};
        for (int t = 0; t < 2; t++) begin
            foreach (codes[i]) begin
                p = $urandom_range(9, 1);
                start(p, p, t ? ctl(1'b0, `DGT_PRE_STOP, `DGT_SRC2_CLOCK, codes[i])
                              : ctl(1'b0, codes[i], `DGT_SRC2_CLOCK, `DGT_PRE_STOP));
                measure(t, gap); chk_count(gap, (p + 1) * div_of(codes[i]));
            end
        end
        $display("test prescale done");
        pin_run = 1'b1;
        p = $urandom_range(6, 1);
        start(p, p, ctl(1'b1, `DGT_PRE_DIV1, `DGT_SRC2_PIN, `DGT_PRE_DIV1));
        measure(0, gap); chk_count(gap, (p + 1) * 8);
        measure(1, gap); chk_count(gap, (p + 1) * 8);
        pin_run = 1'b0;
        p = $urandom_range(5, 1);
        q = $urandom_range(5, 1);
        start(p, q, ctl(1'b0, `DGT_PRE_DIV1, `DGT_SRC2_CASCADE, `DGT_PRE_DIV1));
        measure(1, gap); chk_count(gap, (p + 1) * (q + 1));
        $display("test sources done");
        mask = 16'h1030;
        start(3, 3, ctl(1'b0, `DGT_PRE_DIV1, `DGT_SRC2_CLOCK, `DGT_PRE_DIV1));
        measure(0, gap); chk_count(gap, 0);
        measure(1, gap); chk_count(gap, 0);
        mask = 16'h0000;
        wr(3'h2, 3'h4, 16'h0000);
        rd(3'h2, 3'h0, v);
        rd(3'h2, 3'h0, w); chk_word(w, v);
        p = $urandom_range(9, 2);
        wr(3'h5, 3'h5, 16'(p));
        wr(3'h7, 3'h5, 16'h0000);
        measure(2, gap); chk_count(gap, p + 1);
        $display("test stop mask baud done");
        complete_run();
    end
endmodule // testbench
